// ---- hw/pturs_pkg.sv ----
/*
 package for the ptp unit index and status register bank: offsets, field positions,
 reset values and carrier structs.
 assumes a plain register port with byte addresses and 32-bit data.
*/
package pturs_pkg;
	// ==========================================================
	// register offsets
	localparam logic [11:0] PTURS_OFS_DOMVER = 12'h518;
	localparam logic [11:0] PTURS_OFS_SELECT = 12'h520;
	localparam logic [11:0] PTURS_OFS_TSTAT = 12'h524;
	localparam logic [11:0] PTURS_OFS_IRQMASK = 12'h5b4;
	localparam logic [11:0] PTURS_OFS_WIN_LO = 12'h52c;
	localparam logic [11:0] PTURS_OFS_WIN_HI = 12'h5b3;
	// ==========================================================
	// field positions
	localparam int PTURS_VER_LSB = 8;
	localparam int PTURS_PIN_BIT = 16;
	localparam int PTURS_STAMP_BIT = 8;
	localparam int PTURS_ERR_LSB = 16;
	localparam int PTURS_DOMCHK_BIT = 4;
	// ==========================================================
	// reset values
	localparam logic [3:0] PTURS_VER_RST = 4'h2;
	localparam logic [7:0] PTURS_DOM_RST = 8'h00;
	localparam logic [2:0] PTURS_RSV3_RST = 3'h0;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic valid;
		logic [3:0] version;
		logic [7:0] domain;
	} pturs_msg_t;

	typedef struct packed {
		logic capture;
		logic forward;
		logic drop;
	} pturs_verdict_t;

	typedef struct packed {
		logic pin;
		logic stamp;
		logic [1:0] event_unit;
	} pturs_route_t;
endpackage

// ---- hw/pturs_top.sv ----
/*
 ptp unit index and status register bank: domain and version filter, unit index
 used to route the indexed window, trigger done and error flags with interrupt.
 assumes one 250 mhz clock, a plain register port and trigger units outside.
*/
// Behaviour
// - capture ptp messages only when version equals programmed field, reset value two
// - discard received ptp packets whose version differs from the programmed field
// - with domain checking on, capture only when domain equals programmed domain
// - with domain checking off, domain number is ignored for capture
// - accesses in window 0x52c to 0x5b3 go to the selected units
// - pin selector bit 16 picks second pin when set, first when clear
// - stamp selector bit 8 picks stamp unit one when set, zero when clear
// - event selector codes 0 to 2 pick units; code 3 reserved for software
// - error flag set on late trigger with notify; cleared by dropping trigger enable
// - done flag set when event generated with notify; cleared by writing one
// - highest status bit is unit 2, middle unit 1, lowest unit 0
// - with domain checking on, forward to host when domain and version both match, drop otherwise
`timescale 1ns/1ps
module pturs_top import pturs_pkg::*; #(
	parameter int UNITS = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// received message check
	input wire logic domain_check_enable,
	input wire pturs_msg_t rx_msg,
	output pturs_verdict_t rx_verdict,
	// indexed window routing
	output pturs_route_t route,
	output logic win_wr,
	output logic win_rd,
	output logic [11:0] win_addr,
	output logic [31:0] win_wdata,
	input wire logic [31:0] win_rdata,
	// trigger units
	input wire logic [UNITS-1:0] event_notify_enable,
	input wire logic [UNITS-1:0] event_done,
	input wire logic [UNITS-1:0] event_late,
	input wire logic [UNITS-1:0] event_trigger_enable,
	// interrupt
	output logic irq
);
	// ==========================================================
	// reset release
	logic rst_s1_reg;
	logic rst_n_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg <= rst_s1_reg;
		end
	end

	// ==========================================================
	// decode helpers
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction

	function automatic logic in_window(input logic [11:0] a);
		in_window = (a >= PTURS_OFS_WIN_LO) && (a <= PTURS_OFS_WIN_HI);
	endfunction

	// sticky flag update: a set in the clearing cycle wins over the clear
	function automatic logic [UNITS-1:0] flag_next(input logic [UNITS-1:0] cur, input logic [UNITS-1:0] clr,
		input logic [UNITS-1:0] set);
		flag_next = (cur & ~clr) | set;
	endfunction

	logic sel_domver;
	logic sel_select;
	logic sel_tstat;
	logic sel_mask;
	logic wr_domver;
	logic wr_select;
	logic wr_tstat;
	logic wr_mask;
	logic acc_win;

	assign sel_domver = hit(reg_addr, PTURS_OFS_DOMVER);
	assign sel_select = hit(reg_addr, PTURS_OFS_SELECT);
	assign sel_tstat = hit(reg_addr, PTURS_OFS_TSTAT);
	assign sel_mask = hit(reg_addr, PTURS_OFS_IRQMASK);
	assign wr_domver = reg_wr && sel_domver;
	assign wr_select = reg_wr && sel_select;
	assign wr_tstat = reg_wr && sel_tstat;
	assign wr_mask = reg_wr && sel_mask;
	assign acc_win = in_window(reg_addr);

	// ==========================================================
	// domain and version register
	logic [3:0] version_reg;
	logic [7:0] domain_reg;

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			version_reg <= PTURS_VER_RST;
		end else if (wr_domver) begin
			version_reg <= reg_wdata[PTURS_VER_LSB +: 4];
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			domain_reg <= PTURS_DOM_RST;
		end else if (wr_domver) begin
			domain_reg <= reg_wdata[7:0];
		end
	end

	// ==========================================================
	// unit select register
	logic pin_select_reg;
	logic stamp_unit_select_reg;
	logic [1:0] event_unit_select_reg;
	logic [2:0] rsv_hi_reg;
	logic [2:0] rsv_mid_reg;

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			pin_select_reg <= 1'b0;
		end else if (wr_select) begin
			pin_select_reg <= reg_wdata[PTURS_PIN_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			stamp_unit_select_reg <= 1'b0;
		end else if (wr_select) begin
			stamp_unit_select_reg <= reg_wdata[PTURS_STAMP_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			event_unit_select_reg <= 2'h0;
		end else if (wr_select) begin
			event_unit_select_reg <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rsv_hi_reg <= PTURS_RSV3_RST;
		end else if (wr_select) begin
			rsv_hi_reg <= reg_wdata[19:17];
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rsv_mid_reg <= PTURS_RSV3_RST;
		end else if (wr_select) begin
			rsv_mid_reg <= reg_wdata[11:9];
		end
	end

	// ==========================================================
	// trigger status flags
	logic [UNITS-1:0] done_reg;
	logic [UNITS-1:0] err_reg;
	logic [UNITS-1:0] ten_d_reg;
	logic [UNITS-1:0] done_clr;
	logic [UNITS-1:0] err_clr;

	// per-unit write-one clear of done flags, bit position follows unit number; error flags clear when trigger enable drops
	assign done_clr = wr_tstat ? reg_wdata[UNITS-1:0] : '0;
	assign err_clr = ten_d_reg & ~event_trigger_enable;

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ten_d_reg <= '0;
		end else begin
			ten_d_reg <= event_trigger_enable;
		end
	end

	// a new event in the clearing cycle wins over the clear
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			done_reg <= '0;
		end else begin
			done_reg <= flag_next(done_reg, done_clr, event_done & event_notify_enable);
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			err_reg <= '0;
		end else begin
			err_reg <= flag_next(err_reg, err_clr, event_late & event_notify_enable);
		end
	end

	// ==========================================================
	// interrupt mask, same layout as trigger status
	logic [UNITS-1:0] mask_done_reg;
	logic [UNITS-1:0] mask_err_reg;

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			mask_done_reg <= '0;
		end else if (wr_mask) begin
			mask_done_reg <= reg_wdata[UNITS-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			mask_err_reg <= '0;
		end else if (wr_mask) begin
			mask_err_reg <= reg_wdata[PTURS_ERR_LSB +: UNITS];
		end
	end

	logic [UNITS-1:0] done_pend;
	logic [UNITS-1:0] err_pend;

	assign done_pend = done_reg & mask_done_reg;
	assign err_pend = err_reg & mask_err_reg;

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq <= 1'b0;
		end else begin
			irq <= |(done_pend | err_pend);
		end
	end

	// ==========================================================
	// received message filter
	logic ver_ok;
	logic dom_ok;

	assign ver_ok = (rx_msg.version == version_reg);
	assign dom_ok = !domain_check_enable || (rx_msg.domain == domain_reg);

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rx_verdict <= '0;
		end else begin
			rx_verdict.capture <= rx_msg.valid && ver_ok && dom_ok;
			rx_verdict.forward <= rx_msg.valid && ver_ok && dom_ok;
			rx_verdict.drop <= rx_msg.valid && !(ver_ok && dom_ok);
		end
	end

	// ==========================================================
	// indexed window routing
	// window strobes and copies lag the register port by one cycle
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			route <= '0;
		end else begin
			route.pin <= pin_select_reg;
			route.stamp <= stamp_unit_select_reg;
			route.event_unit <= event_unit_select_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			win_wr <= 1'b0;
		end else begin
			win_wr <= reg_wr && acc_win;
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			win_rd <= 1'b0;
		end else begin
			win_rd <= reg_rd && acc_win;
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			win_addr <= '0;
		end else begin
			win_addr <= reg_addr;
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			win_wdata <= '0;
		end else begin
			win_wdata <= reg_wdata;
		end
	end

	// ==========================================================
	// read data
	logic [31:0] rd_next;

	always_comb begin
		rd_next = 32'h0000_0000;
		if (sel_domver) begin
			rd_next[PTURS_VER_LSB +: 4] = version_reg;
			rd_next[7:0] = domain_reg;
		end else if (sel_select) begin
			rd_next[19:17] = rsv_hi_reg;
			rd_next[PTURS_PIN_BIT] = pin_select_reg;
			rd_next[11:9] = rsv_mid_reg;
			rd_next[PTURS_STAMP_BIT] = stamp_unit_select_reg;
			rd_next[1:0] = event_unit_select_reg;
		end else if (sel_tstat) begin
			rd_next[PTURS_ERR_LSB +: UNITS] = err_reg;
			rd_next[UNITS-1:0] = done_reg;
		end else if (sel_mask) begin
			rd_next[PTURS_ERR_LSB +: UNITS] = mask_err_reg;
			rd_next[UNITS-1:0] = mask_done_reg;
		end
	end

	// window reads are answered by the selected unit in the same cycle
	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= acc_win ? win_rdata : rd_next;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// ---- verification/pturs_monitor.sv ----
/*
 port checker for pturs_top.
 bound from the bench top; sees only the top ports.
*/
`timescale 1ns/1ps
module pturs_monitor import pturs_pkg::*; #(
	parameter int UNITS = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// message check
	input wire logic domain_check_enable,
	input wire pturs_msg_t rx_msg,
	input wire pturs_verdict_t rx_verdict,
	// window
	input wire pturs_route_t route,
	input wire logic win_wr,
	input wire logic win_rd,
	input wire logic [11:0] win_addr,
	input wire logic [31:0] win_wdata,
	input wire logic [31:0] win_rdata,
	// trigger units
	input wire logic [UNITS-1:0] event_notify_enable,
	input wire logic [UNITS-1:0] event_done,
	input wire logic [UNITS-1:0] event_late,
	input wire logic [UNITS-1:0] event_trigger_enable,
	input wire logic irq
);
	// ==========================================================
	// helpers
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic in_win;
	logic sel_wr;
	assign in_win = reg_addr >= PTURS_OFS_WIN_LO && reg_addr <= PTURS_OFS_WIN_HI;
	assign sel_wr = reg_wr && reg_addr[11:2] == PTURS_OFS_SELECT[11:2];
	// ==========================================================
	// assertions
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero");
	a_win_write: assert property (reg_wr && in_win |=> win_wr && win_addr == $past(reg_addr) &&
		win_wdata == $past(reg_wdata)) else $error("window write lost");
	a_win_read: assert property (reg_rd && in_win |=> win_rd && reg_rdata == $past(win_rdata))
		else $error("window read lost");
	a_win_outside: assert property (!(in_win && (reg_wr || reg_rd)) |=> !win_wr && !win_rd)
		else $error("stray window strobe");
	a_verdict_idle: assert property (!rx_msg.valid |=> rx_verdict == 3'h0)
		else $error("stray verdict");
	a_verdict_pair: assert property (rx_msg.valid |=> rx_verdict.forward == rx_verdict.capture &&
		rx_verdict.drop == !rx_verdict.capture) else $error("verdict bits disagree");
	a_route_load: assert property (sel_wr |-> ##2 route == {$past(reg_wdata[16], 2),
		$past(reg_wdata[8], 2), $past(reg_wdata[1:0], 2)}) else $error("route not loaded");
	a_route_hold: assert property (!$stable(route) |-> $past(sel_wr, 2))
		else $error("route changed alone");
	c_sel: cover property (sel_wr);
	c_dom: cover property (rx_msg.valid && domain_check_enable);
	c_irq: cover property (irq);
endmodule

// ---- verification/pturs_tb_top.sv ----
/*
 self-checking bench for pturs_top.
 drives every port itself; one clock at 250 mhz.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; $display("wrong value at %0t: mismatch", $time); end end
module pturs_tb_top import pturs_pkg::*;;
	logic clk, rst_b, reg_wr, reg_rd, domain_check_enable, win_wr, win_rd, irq;
	logic [11:0] reg_addr, win_addr;
	logic [31:0] reg_wdata, reg_rdata, win_wdata, win_rdata, rv;
	logic [2:0] event_notify_enable, event_done, event_late, event_trigger_enable;
	pturs_msg_t rx_msg;
	pturs_verdict_t rx_verdict;
	pturs_route_t route;
	int n_fail, tests_run, cyc, v, d, dc, m;
	pturs_top #(.UNITS(3)) dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.domain_check_enable, .rx_msg, .rx_verdict, .route, .win_wr, .win_rd, .win_addr, .win_wdata,
		.win_rdata, .event_notify_enable, .event_done, .event_late, .event_trigger_enable, .irq);
	// ==========================================================
	// bus and event tasks
	task wr(input logic [11:0] a, input logic [31:0] dt);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= dt;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	task ev(input logic [2:0] dn, input logic [2:0] lt);
		@(posedge clk);
		event_done <= dn;
		event_late <= lt;
		@(posedge clk);
		event_done <= 3'h0;
		event_late <= 3'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task close_out;
		$display("fails %0d checks %0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ==========================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			close_out;
		end
	end
	// ==========================================================
	// scenarios
	initial begin
		{rst_b, reg_wr, reg_rd, domain_check_enable, reg_addr, reg_wdata, win_rdata} = '0;
		{rx_msg, event_done, event_late, n_fail, tests_run, cyc} = '0;
		event_notify_enable = 3'h6;
		event_trigger_enable = 3'h7;
		void'($urandom(1368));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd(PTURS_OFS_DOMVER, 32'h200);
		rd(PTURS_OFS_SELECT, 32'h0);
		rd(PTURS_OFS_TSTAT, 32'h0);
		rd(12'h100, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rv = ($urandom & 32'hffff_fffc) | ($urandom % 3);
			wr(PTURS_OFS_SELECT, rv);
			rd(PTURS_OFS_SELECT, rv & 32'h000f_0f03);
			`CHK(route, {rv[16], rv[8], rv[1:0]})
		end
		wr(PTURS_OFS_DOMVER, 32'hffff_f5a7);
		rd(PTURS_OFS_DOMVER, 32'h0000_05a7);
		for (int i = 0; i < 24; i++) begin
			v = ($urandom % 2) ? 5 : $urandom % 16;
			d = ($urandom % 2) ? 8'ha7 : $urandom % 256;
			dc = $urandom % 2;
			m = (v == 5) && (dc == 0 || d == 8'ha7);
			@(posedge clk);
			rx_msg <= '{1'b1, v[3:0], d[7:0]};
			domain_check_enable <= dc[0];
			@(posedge clk);
			rx_msg.valid <= 1'b0;
			#1;
			`CHK(rx_verdict, {m[0], m[0], !m[0]})
		end
		for (int i = 0; i < 3; i++) begin
			ev(3'h1 << i, 3'h0);
			rd(PTURS_OFS_TSTAT, (i == 0) ? 32'h0 : 32'h1 << i);
			wr(PTURS_OFS_TSTAT, 32'h7);
			rd(PTURS_OFS_TSTAT, 32'h0);
		end
		ev(3'h4, 3'h0);
		`CHK(irq, 1'b0)
		wr(PTURS_OFS_IRQMASK, 32'h7_0007);
		repeat (2) @(posedge clk);
		#1;
		`CHK(irq, 1'b1)
		ev(3'h0, 3'h2);
		rd(PTURS_OFS_TSTAT, 32'h2_0004);
		wr(PTURS_OFS_TSTAT, 32'h7_0004);
		rd(PTURS_OFS_TSTAT, 32'h2_0000);
		`CHK(irq, 1'b1)
		@(posedge clk);
		event_trigger_enable <= 3'h5;
		rd(PTURS_OFS_TSTAT, 32'h0);
		@(posedge clk);
		#1;
		`CHK(irq, 1'b0)
		for (int i = 0; i < 2; i++) begin
			rv = $urandom;
			wr(i ? PTURS_OFS_WIN_LO : 12'h5b0, rv);
			win_rdata <= rv;
			rd(i ? PTURS_OFS_WIN_LO : 12'h5b0, rv);
		end
		close_out;
	end
endmodule
bind pturs_top pturs_monitor #(.UNITS(UNITS)) u_mon (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .domain_check_enable, .rx_msg, .rx_verdict, .route, .win_wr, .win_rd,
	.win_addr, .win_wdata, .win_rdata, .event_notify_enable, .event_done, .event_late,
	.event_trigger_enable, .irq);
